// [rtl/seep_pkg.sv]
// Purpose: shared types and constants for the two-wire eeprom slave
// Assumes: 250 MHz sys_clk, link clock is the serial clock line
// Notes: write-cycle time is a plain default, not a device figure
package seep_pkg;

  // ----------------------------------------
  // protocol constants
  // ----------------------------------------
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam int MEM_WORDS = 16;
  localparam int ADDR_W = 4;

  // ----------------------------------------
  // write cycle timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_WRITE_NS = 4000000;
  localparam int WR_CYCLES_DEF = T_WRITE_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 20;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CTRL = 3'h1,
    ST_ACK = 3'h3,
    ST_ADDR = 3'h2,
    ST_DATA = 3'h6,
    ST_TX = 3'h7,
    ST_MACK = 3'h5
  } seep_st_e;

  typedef struct packed {
    logic tog;
    logic dbit;
  } seep_link_s;

  typedef struct packed {
    seep_st_e st;
    seep_st_e after;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [ADDR_W-1:0] ptr;
    logic [7:0] wbuf;
    logic wvalid;
    logic drv;
    logic macked;
    logic oe;
    logic busy;
    logic [TMR_W-1:0] tmr;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] tog_s;
    logic tog_q;
    logic [MEM_WORDS-1:0][7:0] mem;
  } seep_core_s;

endpackage

// [rtl/seep_link_cap.sv]
// Purpose: capture each data bit on the rising serial clock edge
// Assumes: serial clock stands still outside frames
// Notes: data bit is held until the next edge, so it may cross as is
`timescale 1ns/1ps
module seep_link_cap (
  // link clock and reset
  input wire logic scl,
  input wire logic resetn,
  // serial data in
  input wire logic sda_i,
  // captured bit toward the system domain
  output seep_pkg::seep_link_s cap
);

  seep_pkg::seep_link_s q_ff;
  seep_pkg::seep_link_s nxt_q;

  // ----------------------------------------
  // one toggle per clock pulse
  // ----------------------------------------
  always_comb begin
    nxt_q = q_ff;
    // data is sampled in the high phase, where it is stable
    nxt_q.dbit = sda_i;
    nxt_q.tog = ~q_ff.tog;
  end

  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign cap = q_ff;

endmodule

// [rtl/seep_slave.sv]
// Purpose: two-wire serial slave in front of a sixteen-byte data store
// Assumes: serial lines are open drain with pull-ups outside
// Notes: bits are taken in the link domain, framing in sys_clk
`timescale 1ns/1ps
module seep_slave #(
  parameter int WR_CYCLES = seep_pkg::WR_CYCLES_DEF
) (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // serial link
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // status
  output logic busy
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  seep_pkg::seep_core_s q_ff;
  seep_pkg::seep_core_s nxt_q;
  seep_pkg::seep_link_s lk;

  logic bit_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;
  logic [7:0] nb;

  localparam logic [seep_pkg::TMR_W-1:0] WR_LOAD =
    seep_pkg::TMR_W'(WR_CYCLES);
  localparam logic [seep_pkg::TMR_W-1:0] TMR_ONE =
    seep_pkg::TMR_W'(1);
  // bit count seen at a stop that follows a whole byte
  localparam logic [3:0] CNT_STOP = 4'h1;

  // ----------------------------------------
  // link domain capture
  // ----------------------------------------
  seep_link_cap u_cap (
    .scl(scl),
    .resetn(resetn),
    .sda_i(sda_i),
    .cap(lk)
  );

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic is_ctrl(input logic [7:0] b);
    // the three middle bits are ignored
    is_ctrl = (b[7:4] == seep_pkg::DEV_CODE);
  endfunction

  function automatic logic [3:0] cnt_inc(input logic [3:0] c);
    cnt_inc = c + 4'h1;
  endfunction

  // ----------------------------------------
  // events from synchronised samples
  // ----------------------------------------
  // only second and third stages are looked at, never the first
  assign bit_ev = q_ff.tog_s[1] ^ q_ff.tog_q;
  assign fall_ev = q_ff.scl_s[2] & ~q_ff.scl_s[1];
  // data falling while clock high
  assign start_ev = q_ff.sda_s[2] & ~q_ff.sda_s[1]
    & q_ff.scl_s[2] & q_ff.scl_s[1];
  // data rising while clock high
  assign stop_ev = ~q_ff.sda_s[2] & q_ff.sda_s[1]
    & q_ff.scl_s[2] & q_ff.scl_s[1];
  assign nb = {q_ff.sh[6:0], lk.dbit};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.scl_s = {q_ff.scl_s[1:0], scl};
    nxt_q.sda_s = {q_ff.sda_s[1:0], sda_i};
    nxt_q.tog_s = {q_ff.tog_s[0], lk.tog};
    nxt_q.tog_q = q_ff.tog_s[1];

    // self-timed write cycle
    if (q_ff.busy) begin
      nxt_q.tmr = q_ff.tmr - TMR_ONE;
      if (q_ff.tmr == TMR_ONE) begin
        nxt_q.busy = 1'b0;
      end
    end

    if (stop_ev) begin
      // commit only whole bytes after a full data phase
      // the clock rise leading into a stop is taken as one bit, so a
      // whole byte shows a count of one here, never zero
      if (q_ff.st == seep_pkg::ST_DATA && q_ff.wvalid
          && q_ff.cnt <= CNT_STOP && !q_ff.busy) begin
        // last full byte wins, pointer not advanced
        nxt_q.mem[q_ff.ptr] = q_ff.wbuf;
        nxt_q.busy = 1'b1;
        nxt_q.tmr = WR_LOAD;
      end
      nxt_q.st = seep_pkg::ST_IDLE;
      nxt_q.oe = 1'b0;
      nxt_q.drv = 1'b0;
      nxt_q.wvalid = 1'b0;
    end else if (start_ev) begin
      // a repeated start drops the write but keeps the pointer
      nxt_q.st = seep_pkg::ST_CTRL;
      nxt_q.cnt = 4'h0;
      nxt_q.oe = 1'b0;
      nxt_q.drv = 1'b0;
      nxt_q.wvalid = 1'b0;
    end else begin
      case (q_ff.st)
        seep_pkg::ST_IDLE: begin
          nxt_q.oe = 1'b0;
        end

        seep_pkg::ST_CTRL: begin
          if (bit_ev) begin
            nxt_q.sh = nb;
            nxt_q.cnt = cnt_inc(q_ff.cnt);
            if (q_ff.cnt == seep_pkg::BIT_LAST) begin
              // ack only on match and with no write running
              if (is_ctrl(nb) && !q_ff.busy) begin
                nxt_q.st = seep_pkg::ST_ACK;
                nxt_q.drv = 1'b0;
                // one reads, zero writes an address
                if (nb[0]) begin
                  nxt_q.after = seep_pkg::ST_TX;
                end else begin
                  nxt_q.after = seep_pkg::ST_ADDR;
                end
              end else begin
                // silence on the bus is the poll answer
                nxt_q.st = seep_pkg::ST_IDLE;
              end
            end
          end
        end

        seep_pkg::ST_ACK: begin
          if (fall_ev) begin
            if (!q_ff.drv) begin
              // pull low before the ninth clock rises
              nxt_q.oe = 1'b1;
              nxt_q.drv = 1'b1;
            end else begin
              nxt_q.oe = 1'b0;
              nxt_q.drv = 1'b0;
              nxt_q.cnt = 4'h0;
              nxt_q.st = q_ff.after;
              if (q_ff.after == seep_pkg::ST_TX) begin
                // current location is the pointer: one past the last byte read, or the byte last written
                nxt_q.sh = q_ff.mem[q_ff.ptr];
                nxt_q.oe = ~q_ff.mem[q_ff.ptr][7];
              end
            end
          end
        end

        seep_pkg::ST_ADDR: begin
          if (bit_ev) begin
            nxt_q.sh = nb;
            nxt_q.cnt = cnt_inc(q_ff.cnt);
            if (q_ff.cnt == seep_pkg::BIT_LAST) begin
              // upper four address bits are ignored
              nxt_q.ptr = nb[3:0];
              nxt_q.st = seep_pkg::ST_ACK;
              nxt_q.after = seep_pkg::ST_DATA;
              nxt_q.drv = 1'b0;
            end
          end
        end

        seep_pkg::ST_DATA: begin
          if (bit_ev) begin
            nxt_q.sh = nb;
            nxt_q.cnt = cnt_inc(q_ff.cnt);
            if (q_ff.cnt == seep_pkg::BIT_LAST) begin
              // a later byte replaces the buffered one
              nxt_q.wbuf = nb;
              nxt_q.wvalid = 1'b1;
              nxt_q.st = seep_pkg::ST_ACK;
              nxt_q.after = seep_pkg::ST_DATA;
              nxt_q.drv = 1'b0;
            end
          end
        end

        seep_pkg::ST_TX: begin
          if (bit_ev) begin
            nxt_q.cnt = cnt_inc(q_ff.cnt);
            if (q_ff.cnt == seep_pkg::BIT_LAST) begin
              // step after every byte read, wrapping
              nxt_q.ptr = q_ff.ptr + 4'h1;
              nxt_q.st = seep_pkg::ST_MACK;
              nxt_q.drv = 1'b0;
              nxt_q.macked = 1'b0;
            end
          end else if (fall_ev && q_ff.cnt != 4'h0) begin
            // change data only while the clock is low
            nxt_q.sh = {q_ff.sh[6:0], 1'b0};
            nxt_q.oe = ~q_ff.sh[6];
          end
        end

        seep_pkg::ST_MACK: begin
          if (fall_ev && !q_ff.drv) begin
            // leave the line high for the master's answer
            nxt_q.oe = 1'b0;
            nxt_q.drv = 1'b1;
          end else if (bit_ev) begin
            if (!lk.dbit) begin
              nxt_q.macked = 1'b1;
            end else begin
              // no ack: stop sending, wait for stop
              nxt_q.st = seep_pkg::ST_IDLE;
            end
          end else if (fall_ev && q_ff.macked) begin
            // next sequential byte on master ack
            nxt_q.st = seep_pkg::ST_TX;
            nxt_q.cnt = 4'h0;
            nxt_q.drv = 1'b0;
            nxt_q.sh = q_ff.mem[q_ff.ptr];
            nxt_q.oe = ~q_ff.mem[q_ff.ptr][7];
          end
        end

        default: begin
          nxt_q.st = seep_pkg::ST_IDLE;
          nxt_q.oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // lines idle high, so the sample chains reset high
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q_ff <= '0;
      q_ff.scl_s <= 3'h7;
      q_ff.sda_s <= 3'h7;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain: only ever drives low
  assign sda_o = 1'b0;
  assign sda_oe = q_ff.oe;
  assign busy = q_ff.busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_ack_hold_low:
  assert property (
    (q_ff.st == seep_pkg::ST_ACK && q_ff.drv && !fall_ev
      && !start_ev && !stop_ev) |=> sda_oe
  ) else $error("ack released early");

  a_busy_no_ack:
  assert property (
    (q_ff.st == seep_pkg::ST_CTRL && bit_ev && !start_ev && !stop_ev
      && q_ff.cnt == seep_pkg::BIT_LAST && q_ff.busy)
      |=> q_ff.st == seep_pkg::ST_IDLE
  ) else $error("control byte taken while busy");

  a_ctrl_dir_sel:
  assert property (
    (q_ff.st == seep_pkg::ST_CTRL && bit_ev && !start_ev && !stop_ev
      && q_ff.cnt == seep_pkg::BIT_LAST && !q_ff.busy
      && is_ctrl(nb))
      |=> q_ff.st == seep_pkg::ST_ACK
      && (q_ff.after == seep_pkg::ST_TX) == $past(lk.dbit)
  ) else $error("wrong direction after control byte");

  a_addr_ptr_load:
  assert property (
    (q_ff.st == seep_pkg::ST_ADDR && bit_ev && !start_ev && !stop_ev
      && q_ff.cnt == seep_pkg::BIT_LAST)
      |=> q_ff.ptr == {$past(q_ff.sh[2:0]), $past(lk.dbit)}
  ) else $error("pointer not loaded from address byte");

  a_write_commit:
  assert property (
    (stop_ev && q_ff.st == seep_pkg::ST_DATA && q_ff.wvalid
      && q_ff.cnt <= CNT_STOP && !q_ff.busy)
      |=> q_ff.busy && q_ff.tmr == WR_LOAD
      && q_ff.mem[q_ff.ptr] == $past(q_ff.wbuf)
  ) else $error("write not started on stop");

  a_partial_abort:
  assert property (
    (stop_ev && q_ff.st == seep_pkg::ST_DATA && q_ff.cnt > CNT_STOP
      && !q_ff.busy) |=> !q_ff.busy
  ) else $error("partial byte was written");

  a_read_ptr_step:
  assert property (
    (q_ff.st == seep_pkg::ST_TX && bit_ev && !start_ev && !stop_ev
      && q_ff.cnt == seep_pkg::BIT_LAST)
      |=> q_ff.ptr == 4'($past(q_ff.ptr) + 4'h1)
      && q_ff.st == seep_pkg::ST_MACK
  ) else $error("pointer not stepped after read");

  a_nack_release:
  assert property (
    (q_ff.st == seep_pkg::ST_MACK && fall_ev && !q_ff.drv
      && !start_ev && !stop_ev) |=> !sda_oe [*2]
  ) else $error("line not released for master ack");

  a_busy_end:
  assert property (
    (q_ff.busy && q_ff.tmr == TMR_ONE) |=> !q_ff.busy
  ) else $error("write cycle length wrong");

  a_start_frame:
  assert property (
    (start_ev && !stop_ev) |=> q_ff.st == seep_pkg::ST_CTRL
      && q_ff.cnt == 4'h0 && !sda_oe
  ) else $error("start did not reopen framing");

  a_stop_idle:
  assert property (
    stop_ev |=> q_ff.st == seep_pkg::ST_IDLE && !sda_oe
  ) else $error("stop did not end the frame");

  a_write_ptr_keep:
  assert property (
    (stop_ev && q_ff.st == seep_pkg::ST_DATA && q_ff.wvalid
      && q_ff.cnt <= CNT_STOP && !q_ff.busy)
      |=> q_ff.ptr == $past(q_ff.ptr)
  ) else $error("pointer moved by a byte write");

endmodule

// [test/seep_mst.sv]
// Purpose: bus master model driving the two-wire link of the slave
// Assumes: 160 ns bit time, pull-up on the data wire
// Notes: serial clock stands high between frames
`timescale 1ns/1ps
module seep_mst (
  // serial link
  output logic scl,
  output logic sda_lo,
  input wire logic sda,
  // byte result toward the bench
  output logic rx_stb,
  output logic [8:0] rx_val
);
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
    rx_stb = 1'b0;
    rx_val = 9'h000;
  end
  // --------------------------------------
  // bit level
  // --------------------------------------
  // data moves only mid low phase, far from both clock edges
  task automatic bit_out(input logic b, output logic s);
    #40 sda_lo = ~b;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
  endtask
  task automatic start_c();
    #40 sda_lo = 1'b0;
    #40 scl = 1'b1;
    #40 sda_lo = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop_c();
    #40 sda_lo = 1'b1;
    #40 scl = 1'b1;
    #40 sda_lo = 1'b0;
    #80;
  endtask
  task automatic bits(input int n, input logic [7:0] v);
    logic s;
    for (int i = 0; i < n; i++) bit_out(v[7-i], s);
  endtask
  // --------------------------------------
  // byte level
  // --------------------------------------
  // ninth low is a master ack, high leaves room for the slave ack
  task automatic xfer(input logic [7:0] tx, input logic ninth);
    logic [7:0] r;
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(tx[i], r[i]);
    bit_out(ninth, a);
    rx_val = {a, r};
    rx_stb = 1'b1;
    #1 rx_stb = 1'b0;
  endtask
endmodule

// [test/seep_slave_tb.sv]
// Purpose: self-checking bench for the two-wire eeprom slave
// Assumes: write cycle shortened to 500 sys_clk cycles
// Notes: expected bytes queue up, a watcher compares each result
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module seep_slave_tb;
  localparam int WRC = 500;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, m_lo, sda_w, sda_o, sda_oe, busy, rx_stb;
  logic busy_q = 1'b0;
  logic [8:0] rx_val, e;
  logic [8:0] exp_q[$];
  logic [7:0] mdl [16];
  logic [3:0] ptr;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int bcnt = 0;
  always #2 sys_clk = ~sys_clk;
  // wire is low when either party pulls it, else pulled up
  assign sda_w = !(m_lo || (sda_oe && !sda_o));
  seep_slave #(.WR_CYCLES(WRC)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));
  seep_mst m (.scl(scl), .sda_lo(m_lo), .sda(sda_w), .rx_stb(rx_stb),
    .rx_val(rx_val));
  // --------------------------------------
  // verdict and watchers
  // --------------------------------------
  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      wrap_up();
    end
  end
  always @(posedge sys_clk) begin
    busy_q <= busy;
    if (busy === 1'b1) bcnt <= bcnt + 1;
    else if (busy_q === 1'b1) begin
      `CHK("busy_len", WRC, bcnt)
      bcnt <= 0;
    end
  end
  always @(posedge rx_stb) begin
    if (exp_q.size() == 0) fails++;
    else begin
      e = exp_q.pop_front();
      `CHK("byte", e, rx_val)
    end
  end
  // --------------------------------------
  // transfers
  // --------------------------------------
  function automatic logic [7:0] ctl(input logic rw);
    ctl = {4'ha, 3'($urandom), rw};
  endfunction
  task automatic tx(input logic [7:0] b, input logic ack);
    exp_q.push_back({ack, b});
    m.xfer(b, 1'b1);
  endtask
  task automatic rd(input logic more);
    exp_q.push_back({~more, mdl[ptr]});
    ptr = ptr + 4'h1;
    m.xfer(8'hff, ~more);
  endtask
  task automatic bsy(input logic v);
    repeat (10) @(posedge sys_clk);
    `CHK("busy", v, busy)
  endtask
  // a junk byte first means only the last full byte may land
  task automatic do_write(input logic [7:0] a, input logic [7:0] d,
                          input logic extra);
    m.start_c();
    tx(ctl(1'b0), 1'b0);
    tx(a, 1'b0);
    if (extra) tx(~d, 1'b0);
    tx(d, 1'b0);
    m.stop_c();
    mdl[a[3:0]] = d;
    ptr = a[3:0];
    bsy(1'b1);
    m.start_c();
    tx(ctl(1'b0), 1'b1);
    m.stop_c();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge sys_clk);
    m.start_c();
    tx(ctl(1'b0), 1'b0);
    m.stop_c();
  endtask
  task automatic cur_rd(input int n);
    m.start_c();
    tx(ctl(1'b1), 1'b0);
    for (int i = 0; i < n; i++) rd(i < n - 1);
    m.stop_c();
  endtask
  task automatic rnd_rd(input logic [7:0] a, input int n);
    m.start_c();
    tx(ctl(1'b0), 1'b0);
    tx(a, 1'b0);
    ptr = a[3:0];
    m.start_c();
    tx(ctl(1'b1), 1'b0);
    for (int i = 0; i < n; i++) rd(i < n - 1);
    m.stop_c();
  endtask
  // --------------------------------------
  // main sequence
  // --------------------------------------
  initial begin
    void'($urandom(32'hcdee));
    for (int i = 0; i < 16; i++) mdl[i] = 8'h00;
    ptr = 4'h0;
    repeat (4) @(posedge sys_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("oe_rst", 1'b0, sda_oe)
    cur_rd(1);
    m.start_c();
    tx(8'h2b, 1'b1);
    m.stop_c();
    for (int i = 0; i < 4; i++)
      do_write({4'($urandom), 4'(i * 5)}, 8'($urandom), i == 3);
    cur_rd(1);
    rnd_rd({4'($urandom), 4'he}, 4);
    cur_rd(1);
    m.start_c();
    tx(ctl(1'b0), 1'b0);
    tx(8'h07, 1'b0);
    m.stop_c();
    bsy(1'b0);
    m.start_c();
    tx(ctl(1'b0), 1'b0);
    tx(8'h05, 1'b0);
    tx(8'h11, 1'b0);
    tx(8'h22, 1'b0);
    m.bits(4, 8'h3c);
    m.stop_c();
    bsy(1'b0);
    rnd_rd(8'h05, 1);
    repeat (20) @(posedge sys_clk);
    if (exp_q.size() != 0) fails++;
    wrap_up();
  end
endmodule
